/* hw/rps_consts.svh */
// Timing constants for the reset phase sequencer.
// Assumes a 20 MHz clock; all counts derived from times in their own units.
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH

`define RPS_CLK_HZ          20000000
// Destructive with self-test, ms (min 40, max 51)
`define RPS_DRB_MIN_MS      40
`define RPS_DRB_MAX_MS      51
// Destructive without self-test, us
`define RPS_DR_MIN_US       500
`define RPS_DR_MAX_US       5000
// External long with self-test, ms
`define RPS_ERLB_MIN_MS     41
`define RPS_ERLB_MAX_MS     49
// Functional long / short, us
`define RPS_FRL_MIN_US      35
`define RPS_FRL_MAX_US      400
`define RPS_FRS_MIN_US      1
`define RPS_FRS_MAX_US      10

// Cycle counts: time multiplied by clocks per ms or per us
`define RPS_CYC_MS(t)       ((t) * (`RPS_CLK_HZ / 1000))
`define RPS_CYC_US(t)       ((t) * (`RPS_CLK_HZ / 1000000))

// Nominal sequence targets, set between min and max
`define RPS_DRB_CYC         `RPS_CYC_MS(45)
`define RPS_DR_CYC          `RPS_CYC_US(2000)
`define RPS_ERLB_CYC        `RPS_CYC_MS(45)
`define RPS_FRL_CYC         `RPS_CYC_US(150)
`define RPS_FRS_CYC         `RPS_CYC_US(4)

// Phase share of a sequence, in eighths
`define RPS_OSC_SHARE       1
`define RPS_FLASH_SHARE     1
`define RPS_CFG_SHARE       1
`define RPS_CNT_W           32

`endif

/* hw/rps_pkg.sv */
// Types for the reset phase sequencer.
// Assumes rps_consts.svh holds all numeric constants.
package rps_pkg;

  typedef enum logic [2:0] {
    RPS_SEQ_DESTR_BIST,
    RPS_SEQ_DESTR_NOBIST,
    RPS_SEQ_EXT_LONG_BIST,
    RPS_SEQ_FUNC_LONG,
    RPS_SEQ_FUNC_SHORT
  } rps_seq_t;

  typedef enum logic [3:0] {
    RPS_ST_OSC,
    RPS_ST_FLASH,
    RPS_ST_CFG,
    RPS_ST_ST_SETUP,
    RPS_ST_MEM_TEST,
    RPS_ST_LOGIC_TEST,
    RPS_ST_RUN
  } rps_state_t;

  typedef struct packed {
    logic func_trig;
    logic func_long;
    logic func_pin_en;
    logic ext_long;
    logic bist_en;
  } rps_req_t;

  typedef struct packed {
    logic osc_ok;
    logic flash_done;
    logic cfg_done;
    logic mem_test_done;
    logic logic_test_done;
  } rps_unit_done_t;

  typedef struct packed {
    logic flash_start;
    logic cfg_start;
    logic mem_test_start;
    logic logic_test_start;
  } rps_unit_start_t;

endpackage : rps_pkg

/* hw/rps_reset_phase_sequencer.sv */
// Reset phase sequencer: steps oscillator, flash, configuration, self-test, run.
// Assumes one 20 MHz clock; reset pin sampled synchronously, open drain.
// Notes on behaviour
// - Five sequences: destructive with/without self-test, external long, functional long/short.
// - Internal sequence ends exactly as application run mode begins.
// - Reset pin is bidirectional; outside generator or device may pull low.
// - Device never drives pin high; outside pull-up gives the high level.
// - Device releases its low drive at the end of its sequence.
// - Pin held low externally keeps the sequencer in last configuration phase.
// - Self-test order: osc, flash, config, self-test, flash, config, run.
// - Self-test state does setup, memory test, then logic test.
// - Destructive 40-51 ms with test, 500-5000 us without; external 41-49 ms.
// - Functional long 35-400 us; functional short 1-10 us.
// - External low starts a sequence only if device was running and released.
// - Functional sequences from func_trig drive pin low only when func_pin_en is set; a pin-started short always drives.
`timescale 1ns/1ps
`include "rps_consts.svh"

module rps_reset_phase_sequencer (
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire rps_pkg::rps_req_t       req_i,
  input  wire rps_pkg::rps_unit_done_t done_i,
  input  wire logic                    rst_pin_n_i,
  output logic                         rst_pin_n_o,
  output logic                         rst_pin_oe_o,
  output rps_pkg::rps_unit_start_t     start_o,
  output rps_pkg::rps_state_t          state_o,
  output rps_pkg::rps_seq_t            seq_o,
  output logic                         run_mode_o,
  output logic                         first_fetch_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  rps_pkg::rps_state_t            state_q, state_d;
  rps_pkg::rps_seq_t              seq_q,   seq_d;
  logic                           second_q, second_d;
  logic                           drive_q, drive_d;
  logic                           pin_prev_q, pin_prev_d;
  logic [`RPS_CNT_W-1:0]          cnt_q,   cnt_d;
  logic [`RPS_CNT_W-1:0]          total_q, total_d;
  logic                           fetch_q, fetch_d;
  logic                           bist_seq;
  logic [`RPS_CNT_W-1:0]          slice;
  logic                           boot_q,  boot_d;
  logic                           run_q,   run_d;
  logic                           ext_trig;
  logic                           last_cfg;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  // Cycles per eighth of the chosen total
  assign slice    = total_q >> 3;
  // Sequences that pass through the self-test states
  assign bist_seq = (seq_q == rps_pkg::RPS_SEQ_DESTR_BIST) ||
                    (seq_q == rps_pkg::RPS_SEQ_EXT_LONG_BIST);
  // Final configuration pass of the running sequence
  assign last_cfg = !bist_seq || second_q;
  // Outside low edge while running with the pin released
  assign ext_trig = pin_prev_q && !rst_pin_n_i && !drive_q;

  // ------------------------------------------------------------
  // Sequence lengths
  // ------------------------------------------------------------
  function automatic logic [`RPS_CNT_W-1:0] seq_cycles(input rps_pkg::rps_seq_t s);
    case (s)
      rps_pkg::RPS_SEQ_DESTR_BIST:    seq_cycles = `RPS_CNT_W'(`RPS_DRB_CYC);
      rps_pkg::RPS_SEQ_DESTR_NOBIST:  seq_cycles = `RPS_CNT_W'(`RPS_DR_CYC);
      rps_pkg::RPS_SEQ_EXT_LONG_BIST: seq_cycles = `RPS_CNT_W'(`RPS_ERLB_CYC);
      rps_pkg::RPS_SEQ_FUNC_LONG:     seq_cycles = `RPS_CNT_W'(`RPS_FRL_CYC);
      rps_pkg::RPS_SEQ_FUNC_SHORT:    seq_cycles = `RPS_CNT_W'(`RPS_FRS_CYC);
      default:                        seq_cycles = `RPS_CNT_W'(`RPS_DR_CYC);
    endcase
  endfunction : seq_cycles

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    seq_d      = seq_q;
    second_d   = second_q;
    drive_d    = drive_q;
    cnt_d      = cnt_q;
    total_d    = total_q;
    fetch_d    = 1'b0;
    boot_d     = 1'b0;
    pin_prev_d = rst_pin_n_i;
    if (cnt_q != '0) begin
      cnt_d = cnt_q - `RPS_CNT_W'(1);
    end
    case (state_q)
      rps_pkg::RPS_ST_OSC: begin
        if (done_i.osc_ok && cnt_q == '0) begin
          state_d = rps_pkg::RPS_ST_FLASH;
          cnt_d   = slice;
        end
      end
      rps_pkg::RPS_ST_FLASH: begin
        if (done_i.flash_done && cnt_q == '0) begin
          state_d = rps_pkg::RPS_ST_CFG;
          cnt_d   = slice;
        end
      end
      rps_pkg::RPS_ST_CFG: begin
        if (done_i.cfg_done && cnt_q == '0) begin
          if (!last_cfg) begin
            state_d = rps_pkg::RPS_ST_ST_SETUP;
            cnt_d   = slice;
          end else if (!drive_q && rst_pin_n_i) begin
            state_d  = rps_pkg::RPS_ST_RUN;
            fetch_d  = 1'b1;
          end else begin
            // Own drive off first, so the pin shows the outside level
            drive_d  = 1'b0;
          end
        end
      end
      rps_pkg::RPS_ST_ST_SETUP: begin
        if (cnt_q == '0) begin
          state_d = rps_pkg::RPS_ST_MEM_TEST;
          cnt_d   = slice;
        end
      end
      rps_pkg::RPS_ST_MEM_TEST: begin
        if (done_i.mem_test_done && cnt_q == '0) begin
          state_d = rps_pkg::RPS_ST_LOGIC_TEST;
          cnt_d   = slice;
        end
      end
      rps_pkg::RPS_ST_LOGIC_TEST: begin
        if (done_i.logic_test_done && cnt_q == '0) begin
          state_d  = rps_pkg::RPS_ST_FLASH;
          second_d = 1'b1;
          cnt_d    = slice;
        end
      end
      rps_pkg::RPS_ST_RUN: begin
        // A high-to-low pin edge after release, or func_trig, starts anew
        if (ext_trig) begin
          seq_d    = req_i.ext_long ? rps_pkg::RPS_SEQ_EXT_LONG_BIST
                                    : rps_pkg::RPS_SEQ_FUNC_SHORT;
          drive_d  = 1'b1;
        end else if (req_i.func_trig) begin
          seq_d    = req_i.func_long ? rps_pkg::RPS_SEQ_FUNC_LONG
                                     : rps_pkg::RPS_SEQ_FUNC_SHORT;
          drive_d  = req_i.func_pin_en;
        end
        if (ext_trig || req_i.func_trig) begin
          second_d = 1'b0;
          total_d  = seq_cycles(seq_d);
          cnt_d    = seq_cycles(seq_d) >> 3;
          state_d  = (seq_d == rps_pkg::RPS_SEQ_EXT_LONG_BIST) ? rps_pkg::RPS_ST_OSC
                                                              : rps_pkg::RPS_ST_FLASH;
        end
      end
      default: begin
        state_d = rps_pkg::RPS_ST_OSC;
      end
    endcase
    // First edge after reset: self-test choice from configuration
    if (boot_q) begin
      seq_d   = req_i.bist_en ? rps_pkg::RPS_SEQ_DESTR_BIST
                              : rps_pkg::RPS_SEQ_DESTR_NOBIST;
      total_d = seq_cycles(seq_d);
      cnt_d   = seq_cycles(seq_d) >> 3;
      state_d = rps_pkg::RPS_ST_OSC;
    end
    run_d = (state_d == rps_pkg::RPS_ST_RUN);
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q    <= rps_pkg::RPS_ST_OSC;
      seq_q      <= rps_pkg::RPS_SEQ_DESTR_NOBIST;
      second_q   <= 1'b0;
      drive_q    <= 1'b1;
      pin_prev_q <= 1'b0;
      cnt_q      <= '0;
      total_q    <= '0;
      fetch_q    <= 1'b0;
      boot_q     <= 1'b1;
      run_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      seq_q      <= seq_d;
      second_q   <= second_d;
      drive_q    <= drive_d;
      pin_prev_q <= pin_prev_d;
      cnt_q      <= cnt_d;
      total_q    <= total_d;
      fetch_q    <= fetch_d;
      boot_q     <= boot_d;
      run_q      <= run_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rst_pin_n_o   = 1'b0;
  assign rst_pin_oe_o  = drive_q;
  assign state_o       = state_q;
  assign seq_o         = seq_q;
  assign run_mode_o    = run_q;
  assign first_fetch_o = fetch_q;

  // ------------------------------------------------------------
  // Unit starts
  // ------------------------------------------------------------
  assign start_o.flash_start      = (state_q == rps_pkg::RPS_ST_FLASH);
  assign start_o.cfg_start        = (state_q == rps_pkg::RPS_ST_CFG);
  assign start_o.mem_test_start   = (state_q == rps_pkg::RPS_ST_MEM_TEST);
  assign start_o.logic_test_start = (state_q == rps_pkg::RPS_ST_LOGIC_TEST);

endmodule : rps_reset_phase_sequencer

/* verif/rps_pin_partner.sv */
// Model of the outside reset generator and pull-up on the reset pin.
// Assumes the device side only sinks the pin through its enable.
`timescale 1ns/1ps
module rps_pin_partner (
  input  wire logic dev_oe_i,
  input  wire logic dev_drv_i,
  input  wire logic hold_low_i,
  output logic      pin_n_o
);
  // ----------------------------------------
  // Wired level
  // ----------------------------------------
  // Either party may sink; otherwise pull-up wins
  assign pin_n_o = ((dev_oe_i && !dev_drv_i) || hold_low_i) ? 1'b0 : 1'b1;
endmodule : rps_pin_partner

/* verif/rps_seq_asserts.sv */
// Checker for the reset phase sequencer, bound to its top ports.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module rps_seq_asserts (
  input wire logic                    clk_i,
  input wire logic                    reset_n_i,
  input wire rps_pkg::rps_req_t       req_i,
  input wire rps_pkg::rps_unit_done_t done_i,
  input wire logic                    rst_pin_n_i,
  input wire logic                    rst_pin_n_o,
  input wire logic                    rst_pin_oe_o,
  input wire rps_pkg::rps_unit_start_t start_o,
  input wire rps_pkg::rps_state_t     state_o,
  input wire rps_pkg::rps_seq_t       seq_o,
  input wire logic                    run_mode_o,
  input wire logic                    first_fetch_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // Pin drive, fetch and phase steps
  // ----------------------------------------
  sequence s_left(rps_pkg::rps_state_t from);
    state_o != $past(state_o) && $past(state_o) == from;
  endsequence
  property p_pin_low; rst_pin_oe_o |-> !rst_pin_n_o; endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  property p_fetch; first_fetch_o |-> run_mode_o && !rst_pin_oe_o ##1 !first_fetch_o; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch pulse wrong");
  property p_run_oe; run_mode_o |-> !rst_pin_oe_o; endproperty
  a_run_oe: assert property (p_run_oe) else $error("pin held in run");
  property p_cfg_wait; state_o == rps_pkg::RPS_ST_CFG && !rst_pin_n_i |=> !run_mode_o; endproperty
  a_cfg_wait: assert property (p_cfg_wait) else $error("left config with pin low");
  property p_to_run; $rose(run_mode_o) |-> $past(state_o) == rps_pkg::RPS_ST_CFG && first_fetch_o;
  endproperty
  a_to_run: assert property (p_to_run) else $error("run not from config");
  property p_osc; s_left(rps_pkg::RPS_ST_OSC) |-> state_o == rps_pkg::RPS_ST_FLASH; endproperty
  a_osc: assert property (p_osc) else $error("bad step after osc");
  property p_setup; s_left(rps_pkg::RPS_ST_ST_SETUP) |-> state_o == rps_pkg::RPS_ST_MEM_TEST;
  endproperty
  a_setup: assert property (p_setup) else $error("bad step after setup");
  property p_logic; s_left(rps_pkg::RPS_ST_LOGIC_TEST) |-> state_o == rps_pkg::RPS_ST_FLASH;
  endproperty
  a_logic: assert property (p_logic) else $error("bad step after logic test");
  property p_nobist;
    s_left(rps_pkg::RPS_ST_CFG) ##0 seq_o == rps_pkg::RPS_SEQ_DESTR_NOBIST |-> run_mode_o;
  endproperty
  a_nobist: assert property (p_nobist) else $error("self-test not skipped");
  property p_flash;
    state_o == rps_pkg::RPS_ST_FLASH && !done_i.flash_done |=>
      state_o == rps_pkg::RPS_ST_FLASH && start_o.flash_start;
  endproperty
  a_flash: assert property (p_flash) else $error("flash start missing");
endmodule : rps_seq_asserts

/* verif/rps_reset_phase_sequencer_tb.sv */
// Self-checking bench for the reset phase sequencer.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/1ps
module rps_reset_phase_sequencer_tb;
  logic clk_i = 0, reset_n_i = 0, hold_low = 1, rst_pin_n_i, rst_pin_n_o, rst_pin_oe_o;
  logic run_mode_o, first_fetch_o;
  rps_pkg::rps_req_t        req_i = '0;
  rps_pkg::rps_unit_done_t  done_i = '1;
  rps_pkg::rps_unit_start_t start_o;
  rps_pkg::rps_state_t      state_o;
  rps_pkg::rps_seq_t        seq_o;
  int n_mismatch = 0, num_checks = 0, n;
  logic oe;
  always #25 clk_i = ~clk_i;
  rps_reset_phase_sequencer uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i),
    .done_i(done_i), .rst_pin_n_i(rst_pin_n_i), .rst_pin_n_o(rst_pin_n_o),
    .rst_pin_oe_o(rst_pin_oe_o), .start_o(start_o), .state_o(state_o), .seq_o(seq_o),
    .run_mode_o(run_mode_o), .first_fetch_o(first_fetch_o));
  rps_pin_partner u_pin (.dev_oe_i(rst_pin_oe_o), .dev_drv_i(rst_pin_n_o),
    .hold_low_i(hold_low), .pin_n_o(rst_pin_n_i));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic wait_run(int lim);
    int k;
    k = 0;
    oe = 0;
    while (run_mode_o === 1'b1 && k < 10) begin @(negedge clk_i); k++; end
    for (n = 0; n < lim && run_mode_o !== 1'b1; n++) begin
      @(negedge clk_i);
      oe |= rst_pin_oe_o;
    end
    chk("run_reached", 1, run_mode_o);
    chk("first_fetch", 1, first_fetch_o);
  endtask : wait_run
  task automatic pulse_func(logic lng, logic pen);
    req_i = '{func_trig: 1'b1, func_long: lng, func_pin_en: pen, default: 1'b0};
    @(negedge clk_i);
    req_i.func_trig = 1'b0;
    chk("start_flash", rps_pkg::RPS_ST_FLASH, state_o);
    chk("flash_start", 1, start_o.flash_start);
  endtask : pulse_func
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_destr();
    chk("seq_destr", rps_pkg::RPS_SEQ_DESTR_NOBIST, seq_o);
    chk("oe_reset", 1, rst_pin_oe_o);
    for (n = 0; n < 20000 && state_o !== rps_pkg::RPS_ST_CFG; n++) @(negedge clk_i);
    chk("osc_flash_time", 1, n >= 10000);
    repeat (6000) @(negedge clk_i);
    chk("cfg_held", rps_pkg::RPS_ST_CFG, state_o);
    chk("oe_cfg_released", 0, rst_pin_oe_o);
    chk("cfg_start", 1, start_o.cfg_start);
    chk("drive_level", 0, rst_pin_n_o);
    hold_low = 0;
    wait_run(20000);
    chk("oe_released", 0, rst_pin_oe_o);
    chk("pin_high", 1, rst_pin_n_i);
    $display("t_destr done");
  endtask : t_destr
  task automatic t_func_short();
    pulse_func(1'b0, 1'b1);
    wait_run(400);
    chk("seq_fs", rps_pkg::RPS_SEQ_FUNC_SHORT, seq_o);
    chk("oe_fs", 1, oe);
    chk("time_fs", 1, n >= 20 && n <= 200);
    $display("t_func_short done");
  endtask : t_func_short
  task automatic t_func_long();
    pulse_func(1'b1, 1'b0);
    wait_run(9000);
    chk("seq_fl", rps_pkg::RPS_SEQ_FUNC_LONG, seq_o);
    chk("oe_fl", 0, oe);
    chk("time_fl", 1, n >= 700 && n <= 8000);
    $display("t_func_long done");
  endtask : t_func_long
  task automatic t_ext_pin();
    hold_low = 1;
    done_i.flash_done = 1'b0;
    repeat (30) @(negedge clk_i);
    chk("flash_wait", rps_pkg::RPS_ST_FLASH, state_o);
    done_i.flash_done = 1'b1;
    hold_low = 0;
    wait_run(400);
    chk("seq_ext_short", rps_pkg::RPS_SEQ_FUNC_SHORT, seq_o);
    chk("oe_ext", 1, oe);
    req_i.ext_long = 1'b1;
    hold_low = 1;
    repeat (3) @(negedge clk_i);
    hold_low = 0;
    repeat (3) @(negedge clk_i);
    chk("seq_ext_long", rps_pkg::RPS_SEQ_EXT_LONG_BIST, seq_o);
    chk("state_ext_long", rps_pkg::RPS_ST_OSC, state_o);
    $display("t_ext_pin done");
  endtask : t_ext_pin
  task automatic t_bist_boot();
    reset_n_i = 0;
    req_i = '0;
    req_i.bist_en = 1'b1;
    @(negedge clk_i);
    chk("oe_in_reset", 1, rst_pin_oe_o);
    chk("run_in_reset", 0, run_mode_o);
    reset_n_i = 1;
    @(negedge clk_i);
    chk("seq_bist", rps_pkg::RPS_SEQ_DESTR_BIST, seq_o);
    repeat (6000) @(negedge clk_i);
    chk("osc_bist_slice", rps_pkg::RPS_ST_OSC, state_o);
    chk("oe_bist", 1, rst_pin_oe_o);
    $display("t_bist_boot done");
  endtask : t_bist_boot
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    #5000000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (5) @(negedge clk_i);
    reset_n_i = 1;
    t_destr();
    t_func_short();
    t_func_long();
    t_ext_pin();
    t_bist_boot();
    finish_test();
  end
endmodule : rps_reset_phase_sequencer_tb
bind rps_reset_phase_sequencer rps_seq_asserts u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .req_i(req_i), .done_i(done_i), .rst_pin_n_i(rst_pin_n_i), .rst_pin_n_o(rst_pin_n_o),
  .rst_pin_oe_o(rst_pin_oe_o), .start_o(start_o), .state_o(state_o), .seq_o(seq_o),
  .run_mode_o(run_mode_o), .first_fetch_o(first_fetch_o));
